// File: rtl/syncmd_pkg.sv
// Behaviour
// - horizontal polarity to positive clears flag, event after 38 lines.
// - horizontal polarity to negative sets flag, event after 60 lines.
// - polarity flag 0 means positive sync, 1 means negative sync.
// - while change is sustained, update stored period and presence.
// - once stable, filter counter counts down and update enable drops, freezing both.
// - vertical period is a 12-bit count of base clock divided by 76 per frame.
// - vertical presence uses thresholds FF0H and FC0H for hysteresis.
// - vertical polarity is the input level sampled at a quarter frame.
// - vertical period change counts only after persisting beyond 3 frames.
// - static vertical state raises the mode event at count 4080.
// - two-bit format select picks one of four horizontal output forms.
// - format 1,1 passes input pulses only, no substitution.
// - down counter reloads slightly above period per sync; at zero it substitutes.
// - free-run loads counter from free-run period, ignoring input syncs.
// - 5-bit width counter; output sets on pulse or edge, resets at end.
// - vertical generator clocks on base tick, or on free-run lines in free-run.
// - six captured period, polarity and presence values always readable.
// - any period or polarity change raises the mode event.
// - free-run intervals come from 10-bit horizontal and vertical periods.
// - cross-hatch spacing is each free-run period divided by 32.
// - white pattern edges sit at fixed base clock counts.
// - patterns only in free-run; enable flag and type flag control them.
// - absence flop set at FF0H, cleared when count below FC0H.
// - interrupt request flag sets only on mode changes.
// - detection runs from reset; free-run output is the default format.
package syncmd_pkg;

	// ----------------------------------------
	// base clocks and thresholds
	// ----------------------------------------
	localparam logic [6:0] V_DIV_LAST = 7'h4B;
	localparam logic [11:0] PER_ABSENT = 12'hFF0;
	localparam logic [11:0] PER_PRESENT = 12'hFC0;
	localparam logic [11:0] PER_RESET = 12'hFF0;
	localparam logic [11:0] PER_TOL = 12'h002;
	localparam int SUB_MARGIN_SHIFT = 4;
	localparam int HATCH_SHIFT = 5;

	// ----------------------------------------
	// filter limits
	// ----------------------------------------
	localparam logic [5:0] H_POL_TO_POS = 6'h26;
	localparam logic [5:0] H_POL_TO_NEG = 6'h3C;
	localparam logic [5:0] V_POL_TO_POS = 6'h03;
	localparam logic [5:0] V_POL_TO_NEG = 6'h03;
	localparam logic [3:0] H_CHG_LIMIT = 4'hF;
	localparam logic [3:0] V_CHG_LIMIT = 4'h4;

	// ----------------------------------------
	// white pattern window
	// ----------------------------------------
	localparam logic [11:0] H_WHITE_START = 12'h040;
	localparam logic [11:0] H_WHITE_END = 12'h3C0;
	localparam logic [11:0] V_WHITE_START = 12'h008;
	localparam logic [11:0] V_WHITE_END = 12'h0C0;

	typedef enum logic [1:0] {
		FMT_IN_SUBST = 2'b00,
		FMT_FIXED = 2'b01,
		FMT_FREE = 2'b10,
		FMT_IN_ONLY = 2'b11
	} syncmd_fmt_t;

	typedef struct packed {
		logic [11:0] period;
		logic polarity;
		logic present;
	} syncmd_param_t;

	typedef struct packed {
		logic [11:0] cnt;
		logic [11:0] period;
		logic absent;
		logic polarity;
		logic sample;
		logic [5:0] polCnt;
		logic [3:0] chgCnt;
		logic updEn;
		logic prevPos;
		logic edgeSeen;
		logic evt;
	} syncmd_det_t;

endpackage : syncmd_pkg

// File: rtl/syncmd_detect.sv
`timescale 1ns/1ps
`default_nettype none
module syncmd_detect import syncmd_pkg::*; #(
	parameter logic [5:0] POL_TO_POS = 6'h01,
	parameter logic [5:0] POL_TO_NEG = 6'h01,
	parameter logic [3:0] CHG_LIMIT = 4'h1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic tick,
	input wire logic syncRaw,
	output logic syncPos,
	output logic syncEdge,
	output logic updateEnable,
	output syncmd_param_t param,
	output logic modeEvt
);

	syncmd_det_t q;
	syncmd_det_t d;
	logic pos;
	logic edgeNow;
	logic [11:0] diff;
	logic changed;
	logic updNow;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.evt = 1'b0;
		pos = syncRaw ^ q.polarity;
		edgeNow = pos & ~q.prevPos;
		d.prevPos = pos;
		d.edgeSeen = edgeNow;
		diff = (q.cnt > q.period) ? (q.cnt - q.period) : (q.period - q.cnt);
		changed = diff > PER_TOL;
		updNow = q.updEn | (changed & (q.chgCnt == CHG_LIMIT - 4'h1));
		if (tick && !q.absent && q.cnt == (q.period >> 2))
			d.sample = syncRaw;
		if (edgeNow)
		begin
			d.cnt = 12'h000;
			if (changed)
			begin
				if (updNow)
				begin
					d.updEn = 1'b1;
					d.chgCnt = CHG_LIMIT;
					d.period = q.cnt;
					d.evt = 1'b1;
					if (q.cnt < PER_PRESENT)
						d.absent = 1'b0;
				end
				else
					d.chgCnt = q.chgCnt + 4'h1;
			end
			else
			begin
				if (q.chgCnt != 4'h0)
					d.chgCnt = q.chgCnt - 4'h1;
				if (q.chgCnt <= 4'h1)
					d.updEn = 1'b0;
			end
			if (q.sample != q.polarity)
			begin
				if (q.polCnt + 6'h01 >= (q.polarity ? POL_TO_POS : POL_TO_NEG))
				begin
					d.polarity = q.sample;
					d.polCnt = 6'h00;
					d.evt = 1'b1;
				end
				else
					d.polCnt = q.polCnt + 6'h01;
			end
			else
				d.polCnt = 6'h00;
		end
		else if (tick && q.cnt < PER_ABSENT)
			d.cnt = q.cnt + 12'h001;
		else if (q.cnt >= PER_ABSENT && !q.absent)
		begin
			d.absent = 1'b1;
			d.period = PER_ABSENT;
			d.evt = 1'b1;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			q <= '{cnt: 12'h000, period: PER_RESET, absent: 1'b1, polarity: 1'b0, sample: 1'b0,
				polCnt: 6'h00, chgCnt: 4'h0, updEn: 1'b0, prevPos: 1'b0, edgeSeen: 1'b0, evt: 1'b0};
		else if (clkEn)
			q <= d;
	end

	assign syncPos = q.prevPos;
	assign syncEdge = q.edgeSeen;
	assign updateEnable = q.updEn;
	assign param = '{period: q.period, polarity: q.polarity, present: ~q.absent};
	assign modeEvt = q.evt;

endmodule : syncmd_detect
`default_nettype wire

// File: rtl/syncmd_sync_gen.sv
`timescale 1ns/1ps
`default_nettype none
module syncmd_sync_gen import syncmd_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic hSyncIn,
	input wire logic vSyncIn,
	input wire logic hFormatSelHi,
	input wire logic hFormatSelLo,
	input wire logic [9:0] hFreeRunPeriod,
	input wire logic [9:0] vFreeRunPeriod,
	input wire logic [4:0] hOutPulseWidth,
	input wire logic [3:0] vOutPulseWidth,
	input wire logic patternEnableFlag,
	input wire logic patternTypeFlag,
	input wire logic irqClear,
	output syncmd_param_t hParam,
	output syncmd_param_t vParam,
	output logic hUpdateEnable,
	output logic hSyncOutput,
	output logic vSyncOutput,
	output logic patternVideo,
	output logic extIrqRequestFlag
);

	typedef struct packed {
		logic hS1;
		logic hS2;
		logic vS1;
		logic vS2;
		logic [6:0] vDiv;
		logic vTick;
		logic [11:0] hDown;
		logic [4:0] hWidth;
		logic hFixed;
		logic hOut;
		logic [11:0] vDown;
		logic [5:0] vWidth;
		logic vFixed;
		logic vOut;
		logic [11:0] hPos;
		logic [11:0] vPos;
		logic [4:0] hHatch;
		logic [4:0] vHatch;
		logic pattern;
		logic irq;
	} syncmd_main_t;

	syncmd_main_t q;
	syncmd_main_t d;
	syncmd_fmt_t fmt;
	logic freeRun;
	logic hSyncPos;
	logic hEdge;
	logic hEvt;
	logic vSyncPos;
	logic vEdge;
	logic vEvt;
	logic hSubst;
	logic vClk;
	logic vSubst;
	logic [12:0] hLoadWide;
	logic [12:0] vLoadWide;
	logic [11:0] hLoad;
	logic [11:0] vLoad;
	logic [11:0] hFreeLoad;
	logic [11:0] vFreeLoad;
	logic [5:0] vWidthLoad;
	logic whiteOn;
	logic hatchOn;

	// ----------------------------------------
	// mode detectors
	// ----------------------------------------
	syncmd_detect #(
		.POL_TO_POS(H_POL_TO_POS),
		.POL_TO_NEG(H_POL_TO_NEG),
		.CHG_LIMIT(H_CHG_LIMIT)
	) hDet (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.tick(1'b1),
		.syncRaw(q.hS2),
		.syncPos(hSyncPos),
		.syncEdge(hEdge),
		.updateEnable(hUpdateEnable),
		.param(hParam),
		.modeEvt(hEvt)
	);

	syncmd_detect #(
		.POL_TO_POS(V_POL_TO_POS),
		.POL_TO_NEG(V_POL_TO_NEG),
		.CHG_LIMIT(V_CHG_LIMIT)
	) vDet (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.tick(q.vTick),
		.syncRaw(q.vS2),
		.syncPos(vSyncPos),
		.syncEdge(vEdge),
		.updateEnable(),
		.param(vParam),
		.modeEvt(vEvt)
	);

	// ----------------------------------------
	// derived loads
	// ----------------------------------------
	always_comb
	begin
		fmt = syncmd_fmt_t'({hFormatSelHi, hFormatSelLo});
		freeRun = (fmt == FMT_FREE);
		hLoadWide = {1'b0, hParam.period} + {1'b0, hParam.period >> SUB_MARGIN_SHIFT} + 13'h0001;
		vLoadWide = {1'b0, vParam.period} + {1'b0, vParam.period >> SUB_MARGIN_SHIFT} + 13'h0001;
		hLoad = hLoadWide[12] ? 12'hFFF : hLoadWide[11:0];
		vLoad = vLoadWide[12] ? 12'hFFF : vLoadWide[11:0];
		hFreeLoad = {2'b00, hFreeRunPeriod} - 12'h001;
		vFreeLoad = {1'b0, vFreeRunPeriod, 1'b0} - 12'h001;
		vWidthLoad = {1'b0, vOutPulseWidth, 1'b0} + 6'h04;
		hSubst = (q.hDown == 12'h000) && (fmt != FMT_IN_ONLY);
		vClk = freeRun ? hSubst : q.vTick;
		vSubst = vClk && (q.vDown == 12'h000) && (fmt != FMT_IN_ONLY);
		whiteOn = (q.hPos >= H_WHITE_START) && (q.hPos < H_WHITE_END)
			&& (q.vPos >= V_WHITE_START) && (q.vPos < V_WHITE_END);
		hatchOn = (q.hHatch == 5'h00) || (q.vHatch == 5'h00);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.hS1 = hSyncIn;
		d.hS2 = q.hS1;
		d.vS1 = vSyncIn;
		d.vS2 = q.vS1;

		// vertical base tick
		if (q.vDiv == V_DIV_LAST)
		begin
			d.vDiv = 7'h00;
			d.vTick = 1'b1;
		end
		else
		begin
			d.vDiv = q.vDiv + 7'h01;
			d.vTick = 1'b0;
		end

		// horizontal down counter
		if (hSubst)
			d.hDown = freeRun ? hFreeLoad : hLoad;
		else if (hEdge && !freeRun)
			d.hDown = hLoad;
		else if (q.hDown != 12'h000)
			d.hDown = q.hDown - 12'h001;

		// horizontal output flop
		if (hSubst || (hEdge && fmt == FMT_FIXED))
		begin
			d.hOut = 1'b1;
			d.hFixed = 1'b1;
			d.hWidth = hOutPulseWidth;
		end
		else if (hEdge && !freeRun)
		begin
			d.hOut = 1'b1;
			d.hFixed = 1'b0;
		end
		else if (q.hFixed)
		begin
			if (q.hWidth <= 5'h01)
			begin
				d.hOut = 1'b0;
				d.hFixed = 1'b0;
			end
			else
				d.hWidth = q.hWidth - 5'h01;
		end
		else if (q.hOut && !hSyncPos)
			d.hOut = 1'b0;

		// vertical down counter
		if (vSubst)
			d.vDown = freeRun ? vFreeLoad : vLoad;
		else if (vEdge && !freeRun)
			d.vDown = vLoad;
		else if (vClk && q.vDown != 12'h000)
			d.vDown = q.vDown - 12'h001;

		// vertical output flop
		if (vSubst || (vEdge && fmt == FMT_FIXED))
		begin
			d.vOut = 1'b1;
			d.vFixed = 1'b1;
			d.vWidth = vWidthLoad;
		end
		else if (vEdge && !freeRun)
		begin
			d.vOut = 1'b1;
			d.vFixed = 1'b0;
		end
		else if (q.vFixed)
		begin
			if (vClk)
			begin
				if (q.vWidth <= 6'h01)
				begin
					d.vOut = 1'b0;
					d.vFixed = 1'b0;
				end
				else
					d.vWidth = q.vWidth - 6'h01;
			end
		end
		else if (q.vOut && !vSyncPos)
			d.vOut = 1'b0;

		// pattern position counters
		if (hSubst)
		begin
			d.hPos = 12'h000;
			d.hHatch = hFreeRunPeriod[9:HATCH_SHIFT];
			if (vSubst)
				d.vHatch = vFreeRunPeriod[9:HATCH_SHIFT];
			else if (q.vHatch == 5'h00)
				d.vHatch = vFreeRunPeriod[9:HATCH_SHIFT];
			else
				d.vHatch = q.vHatch - 5'h01;
		end
		else
		begin
			if (q.hPos != 12'hFFF)
				d.hPos = q.hPos + 12'h001;
			if (q.hHatch == 5'h00)
				d.hHatch = hFreeRunPeriod[9:HATCH_SHIFT];
			else
				d.hHatch = q.hHatch - 5'h01;
		end
		if (vSubst)
			d.vPos = 12'h000;
		else if (q.vTick && q.vPos != 12'hFFF)
			d.vPos = q.vPos + 12'h001;

		d.pattern = patternEnableFlag && freeRun && (patternTypeFlag ? hatchOn : whiteOn);

		// interrupt request flag, a new event wins over the clear
		if (hEvt || vEvt)
			d.irq = 1'b1;
		else if (irqClear)
			d.irq = 1'b0;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			q <= '{hS1: 1'b0, hS2: 1'b0, vS1: 1'b0, vS2: 1'b0, vDiv: 7'h00, vTick: 1'b0,
				hDown: 12'h000, hWidth: 5'h00, hFixed: 1'b0, hOut: 1'b0,
				vDown: 12'h000, vWidth: 6'h00, vFixed: 1'b0, vOut: 1'b0,
				hPos: 12'h000, vPos: 12'h000, hHatch: 5'h00, vHatch: 5'h00,
				pattern: 1'b0, irq: 1'b0};
		else if (clkEn)
			q <= d;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign hSyncOutput = q.hOut;
	assign vSyncOutput = q.vOut;
	assign patternVideo = q.pattern;
	assign extIrqRequestFlag = q.irq;

endmodule : syncmd_sync_gen
`default_nettype wire

// File: dv/syncmd_sync_gen_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module syncmd_sync_gen_assertions import syncmd_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hSyncIn,
	input wire logic hFormatSelHi,
	input wire logic hFormatSelLo,
	input wire logic [9:0] hFreeRunPeriod,
	input wire logic [4:0] hOutPulseWidth,
	input wire logic irqClear,
	input wire logic patternEnableFlag,
	input wire syncmd_param_t hParam,
	input wire syncmd_param_t vParam,
	input wire logic hSyncOutput,
	input wire logic patternVideo,
	input wire logic extIrqRequestFlag
);
	logic free;
	logic onlyIn;
	logic fixd;
	logic [3:0] quietH;
	logic [3:0] prmAge;
	assign free = hFormatSelHi & ~hFormatSelLo;
	assign onlyIn = hFormatSelHi & hFormatSelLo;
	assign fixd = ~hFormatSelHi & hFormatSelLo;
	// ----------------------------------------
	// input quiet time and parameter age
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			quietH <= 4'h0;
			prmAge <= 4'hF;
		end
		else
		begin
			quietH <= $changed(hSyncIn) ? 4'h0 : ((quietH == 4'hF) ? quietH : quietH + 4'h1);
			prmAge <= ($changed(hParam) || $changed(vParam)) ? 4'h0 : ((prmAge == 4'hF) ? prmAge : prmAge + 4'h1);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_pulse2;
		hSyncOutput ##1 hSyncOutput ##1 !hSyncOutput;
	endsequence
	sequence s_freeRise;
		free && $rose(hSyncOutput);
	endsequence
	property p_freeWidth;
		s_freeRise and hOutPulseWidth == 5'h02 |-> s_pulse2;
	endproperty
	property p_freePeriod;
		s_freeRise and hFreeRunPeriod == 10'h010 |-> ##16 ($rose(hSyncOutput) || !free);
	endproperty
	property p_widthBound;
		$rose(hSyncOutput) && (free || fixd) |-> ##[1:33] !hSyncOutput;
	endproperty
	property p_onlyInput;
		onlyIn && quietH == 4'hF |-> !$rose(hSyncOutput);
	endproperty
	property p_patOff;
		(!free || !patternEnableFlag)[*4] |-> !patternVideo;
	endproperty
	property p_irqFall;
		$fell(extIrqRequestFlag) |-> $past(irqClear);
	endproperty
	property p_irqCause;
		$rose(extIrqRequestFlag) |-> ##[0:3] (prmAge < 4'h6);
	endproperty
	property p_hPresent;
		hParam.present |-> hParam.period < 12'hFC0;
	endproperty
	property p_vPresent;
		vParam.present |-> vParam.period < 12'hFC0;
	endproperty
	a_freeWidth: assert property (p_freeWidth) else $error("free pulse width wrong");
	a_freePeriod: assert property (p_freePeriod) else $error("free pulse spacing wrong");
	a_widthBound: assert property (p_widthBound) else $error("pulse not ended by width count");
	a_onlyInput: assert property (p_onlyInput) else $error("pulse without input sync");
	a_patOff: assert property (p_patOff) else $error("pattern outside free run");
	a_irqFall: assert property (p_irqFall) else $error("request flag dropped without clear");
	a_irqCause: assert property (p_irqCause) else $error("request flag without mode change");
	a_hPresent: assert property (p_hPresent) else $error("horizontal present above limit");
	a_vPresent: assert property (p_vPresent) else $error("vertical present above limit");
endmodule : syncmd_sync_gen_assertions
`default_nettype wire

// File: dv/syncmd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module syncmd_host_model #(
	parameter int H_PER = 200,
	parameter int V_LINES = 10
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic neg,
	output logic hSync,
	output logic vSync
);
	int hCnt;
	int lnCnt;
	// stopped host holds its sync lines at the idle level
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hCnt <= 0;
			lnCnt <= 0;
		end
		else if (run)
		begin
			hCnt <= (hCnt == H_PER - 1) ? 0 : hCnt + 1;
			if (hCnt == H_PER - 1)
				lnCnt <= (lnCnt == V_LINES - 1) ? 0 : lnCnt + 1;
		end
	end
	assign hSync = neg ^ (run && hCnt < 4);
	assign vSync = run && lnCnt < 2;
endmodule : syncmd_host_model
`default_nettype wire

// File: dv/tb_syncmd_sync_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tb_syncmd_sync_gen import syncmd_pkg::*;;
	logic clk, rst_b, clkEn, hIn, vIn, patEn, pattern_type_flag, irqClr, run, neg;
	logic [1:0] fmt;
	logic [9:0] hfp, v_free_run_period;
	logic [4:0] h_out_pulse_width;
	logic [3:0] v_out_pulse_width;
	syncmd_param_t hParam, vParam;
	logic hUpd, hOut, vOut, patVid, irq, hPrev;
	int badCount, cmpCount, cycCount, p, w, n, f;
	int wexp [4] = '{4, 2, 2, 4};
	syncmd_sync_gen dut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .hSyncIn(hIn), .vSyncIn(vIn),
		.hFormatSelHi(fmt[1]), .hFormatSelLo(fmt[0]), .hFreeRunPeriod(hfp), .vFreeRunPeriod(v_free_run_period),
		.hOutPulseWidth(h_out_pulse_width), .vOutPulseWidth(v_out_pulse_width), .patternEnableFlag(patEn), .patternTypeFlag(pattern_type_flag),
		.irqClear(irqClr), .hParam(hParam), .vParam(vParam), .hUpdateEnable(hUpd), .hSyncOutput(hOut),
		.vSyncOutput(vOut), .patternVideo(patVid), .extIrqRequestFlag(irq));
	syncmd_host_model host (.clk(clk), .rst_b(rst_b), .run(run), .neg(neg), .hSync(hIn), .vSync(vIn));
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cycCount++;
		if (cycCount == 60000)
		begin
			badCount++;
			reportAndStop();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			badCount++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	function logic outSel(input logic sel);
		return sel ? vOut : hOut;
	endfunction : outSel
	task wrise(input logic sel);
		int i;
		for (i = 0; i < 2000 && outSel(sel) !== 1'b0; i++) @(posedge clk);
		for (i = 0; i < 2000 && outSel(sel) !== 1'b1; i++) @(posedge clk);
	endtask : wrise
	task measPer(input logic sel, output int per);
		time t0;
		wrise(sel);
		t0 = $time;
		wrise(sel);
		per = int'(($time - t0) / 25);
	endtask : measPer
	task measWid(output int wid);
		wrise(1'b0);
		wid = 0;
		while (hOut === 1'b1 && wid < 100)
		begin
			wid++;
			@(posedge clk);
		end
	endtask : measWid
	task clearIrq();
		@(posedge clk) irqClr <= 1'b1;
		@(posedge clk) irqClr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : clearIrq
	task reportAndStop();
		$display("comparisons %0d mismatches %0d", cmpCount, badCount);
		if (badCount == 0 && cmpCount > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : reportAndStop
	initial
	begin
		clk = 0; rst_b = 0; clkEn = 1; fmt = 2'b10; hfp = 10'h010; v_free_run_period = 10'h004; h_out_pulse_width = 5'h02;
		v_out_pulse_width = 4'h0; patEn = 1; pattern_type_flag = 1; irqClr = 0; run = 1; neg = 0;
		repeat (16) @(posedge clk);
		chk(hParam, {12'hFF0, 1'b0, 1'b0});
		rst_b <= 1'b1;
		measPer(1'b0, p); chk(p, 16);
		measWid(w); chk(w, 2);
		measPer(1'b1, p); chk(p, 128);
		n = 0;
		repeat (256) @(posedge clk) n += (patVid === 1'b1);
		chk(n != 0, 1);
		pattern_type_flag <= 1'b0;
		n = 0;
		repeat (2) @(posedge clk);
		repeat (256) @(posedge clk) n += (patVid === 1'b1);
		chk(n, 0);
		$display("test free_run done");
		fmt <= 2'b00;
		repeat (3000) @(posedge clk);
		chk(hUpd, 1);
		repeat (5000) @(posedge clk);
		chk(hUpd, 0);
		chk(hParam.present, 1);
		chk(hParam.period >= 12'h0C7 && hParam.period <= 12'h0C9, 1);
		chk(hParam.polarity, 0);
		chk(vParam.present, 1);
		chk(irq, 1);
		clearIrq(); chk(irq, 0);
		$display("test lock done");
		for (f = 0; f < 4; f++)
		begin
			fmt <= f[1:0];
			repeat (400) @(posedge clk);
			measWid(w); chk(w, wexp[f]);
		end
		$display("test formats done");
		fmt <= 2'b00;
		clearIrq();
		neg <= 1'b1;
		repeat (8000) @(posedge clk);
		chk(hParam.polarity, 0);
		repeat (6000) @(posedge clk);
		chk(hParam.polarity, 1);
		chk(irq, 1);
		clearIrq();
		neg <= 1'b0;
		repeat (6000) @(posedge clk);
		chk(hParam.polarity, 1);
		repeat (3000) @(posedge clk);
		chk(hParam.polarity, 0);
		chk(irq, 1);
		$display("test polarity done");
		clearIrq();
		run <= 1'b0;
		repeat (8) @(posedge clk);
		measWid(w); chk(w, 2);
		fmt <= 2'b11;
		n = 0;
		hPrev = hOut;
		repeat (600)
		begin
			@(posedge clk);
			n += (hOut === 1'b1 && hPrev === 1'b0);
			hPrev = hOut;
		end
		chk(n, 0);
		repeat (4000) @(posedge clk);
		chk(hParam.present, 0);
		chk(irq, 1);
		$display("test missing_sync done");
		reportAndStop();
	end
endmodule : tb_syncmd_sync_gen
bind syncmd_sync_gen syncmd_sync_gen_assertions chk_i (.clk(clk), .rst_b(rst_b), .hSyncIn(hSyncIn),
	.hFormatSelHi(hFormatSelHi), .hFormatSelLo(hFormatSelLo), .hFreeRunPeriod(hFreeRunPeriod),
	.hOutPulseWidth(hOutPulseWidth), .irqClear(irqClear), .patternEnableFlag(patternEnableFlag),
	.hParam(hParam), .vParam(vParam),
	.hSyncOutput(hSyncOutput), .patternVideo(patternVideo), .extIrqRequestFlag(extIrqRequestFlag));
`default_nettype wire
